// *** rtl/tsp1_clkdiv.sv ***
// Internal shift clock divider: one tick per half period of the selected rate
`timescale 1ns/1ps
`default_nettype none
`include "tsp1_defs.svh"
module tsp1_clkdiv (
	input wire logic i_clk,
	input wire logic i_rst_n,
	tsp1_tick_if.gen tk
);
	// Rates do not divide the clock evenly; half periods round down
	localparam int HALF_01 = `TSP1_CLK_HZ / (2 * `TSP1_RATE_01_HZ);
	localparam int HALF_10 = `TSP1_CLK_HZ / (2 * `TSP1_RATE_10_HZ);
	localparam int HALF_11 = `TSP1_CLK_HZ / (2 * `TSP1_RATE_11_HZ);
	localparam int W = tsp1_pkg::TSP1_DIV_W;

	tsp1_pkg::tsp1_div_t s_q;
	tsp1_pkg::tsp1_div_t s_d;
	logic [W-1:0] last;

	always_comb begin
		case (tk.sel)
			2'h1: last = W'(HALF_01 - 1);
			2'h2: last = W'(HALF_10 - 1);
			2'h3: last = W'(HALF_11 - 1);
			default: last = '0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!tk.run) begin
			// Restart so the first half period after release is full length
			s_d.cnt = '0;
		end else if (s_q.cnt >= last) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tk.tick = s_q.tick;
endmodule : tsp1_clkdiv
`default_nettype wire

// *** rtl/tsp1_defs.svh ***
// Constants for the three-wire serial port: field positions, reset values, rates
`ifndef TSP1_DEFS_SVH
`define TSP1_DEFS_SVH

// ----------------------------------------------------------------
// Mode selection register fields and reset values
// ----------------------------------------------------------------
`define TSP1_TS_BIT 3
`define TSP1_HIZ_BIT 2
`define TSP1_CKH_BIT 1
`define TSP1_CKL_BIT 0
`define TSP1_MODE_RST 4'h0
`define TSP1_SFR_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSP1_CLK_HZ 25000000
`define TSP1_RATE_01_HZ 187500
`define TSP1_RATE_10_HZ 375000
`define TSP1_RATE_11_HZ 46875
`define TSP1_BITS 8

`endif

// *** rtl/tsp1_pkg.sv ***
// Types shared by the three-wire serial port modules
package tsp1_pkg;

	// ----------------------------------------------------------------
	// Port state
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		TSP1_ST_WAIT = 1'b0,
		TSP1_ST_RUN = 1'b1
	} tsp1_state_t;

	parameter int TSP1_DIV_W = 9;

	typedef struct packed {
		logic [TSP1_DIV_W-1:0] cnt;
		logic tick;
	} tsp1_div_t;

	typedef struct packed {
		tsp1_state_t state;
		logic ts;
		logic hiz;
		logic [1:0] cksel;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic sck_int;
		logic sck_prev;
		logic so_bit;
		logic irq;
		logic sck_o;
		logic sck_oe;
		logic so_o;
		logic so_oe;
		logic si_o;
		logic si_oe;
		logic [7:0] sfr_rd;
		logic [3:0] mode_rd;
		logic [2:0] pin_rd;
	} tsp1_core_t;

endpackage : tsp1_pkg

// *** rtl/tsp1_sync.sv ***
// Two-flop synchroniser, vector wide
`timescale 1ns/1ps
`default_nettype none
module tsp1_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} tsp1_sync_t;

	tsp1_sync_t s_q;
	tsp1_sync_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = i_d;
		s_d.stab = s_q.meta;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_q = s_q.stab;
endmodule : tsp1_sync
`default_nettype wire

// *** rtl/tsp1_tick_if.sv ***
// Rate select and half-period tick between the port core and its divider
`timescale 1ns/1ps
`default_nettype none
interface tsp1_tick_if;
	logic [1:0] sel;
	logic run;
	logic tick;
	modport gen (input sel, input run, output tick);
	modport use_side (output sel, output run, input tick);
endinterface : tsp1_tick_if
`default_nettype wire

// *** rtl/tsp1_top.sv ***
// Three-wire serial port one: shift register, wait control, clock counter, pin muxing
// Behaviour
// - Eight-bit shift register holds send and receive data, software loads and reads it.
// - On each shift clock fall, register MSB goes to the data output.
// - On each shift clock rise, data input pin enters the register LSB.
// - Transfer begins only when software sets the start flag to one.
// - After eight shift clocks following release, port returns to wait by itself.
// - Reading the start flag shows whether a transfer is still running.
// - Writing zero to start flag while released forces wait and clears counter.
// - Clock counter starts at zero, counts rises, wraps to zero after eight.
// - Resets, clock stop and a zero start write clear the clock counter.
// - After eight clocks, clock pin goes high; counter and shift register halt.
// - Interrupt request rises on the shift clock rise where count reaches eight.
// - Master with clock pin output holds the clock pin high during wait.
// - Setting start again while released leaves clock and counter untouched.
// - Internal clock: value written in wait shows MSB at first fall after release.
// - Write while released with clock high is taken, MSB shows at once.
// - Clock select zero means slave; any other value means master.
// - Slave clock pin takes external clock when released; master drives internal clock.
// - Data output pin shifts data only with function select set and direction out.
// - Data input pin receives with direction zero, drives port latch with one.
// - Resets keep or drop directions outside; register contents count as undefined.
// - Clock select: 00 external, 01 187.5k, 10 375k, 11 46.875k.
// - Start flag is bit 3, function select bit 2; both clear on reset.
`timescale 1ns/1ps
`default_nettype none
`include "tsp1_defs.svh"
module tsp1_top (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_WDT_RST,
	input wire logic I_CE_RST,
	input wire logic I_CLK_STOP,
	input wire logic I_MODE_WR,
	input wire logic [3:0] I_MODE_WDATA,
	output logic [3:0] O_MODE_RDATA,
	input wire logic I_SFR_WR,
	input wire logic [7:0] I_SFR_WDATA,
	output logic [7:0] O_SFR_RDATA,
	input wire logic I_CLK_DIR,
	input wire logic I_DO_DIR,
	input wire logic I_DI_DIR,
	input wire logic [2:0] I_PORT_LATCH,
	output logic [2:0] O_PIN_RDATA,
	input wire logic I_SCK,
	output logic O_SCK,
	output logic O_SCK_OE,
	input wire logic I_SO,
	output logic O_SO,
	output logic O_SO_OE,
	input wire logic I_SI,
	output logic O_SI,
	output logic O_SI_OE,
	output logic O_IRQ
);
	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_n;
	logic [2:0] pins_s;
	logic sck_s;
	logic so_s;
	logic si_s;

	tsp1_sync #(.W(1)) u_rst_sync (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_B),
		.i_d(1'b1),
		.o_q(rst_n)
	);

	tsp1_sync #(.W(3)) u_pin_sync (
		.i_clk(I_CLK),
		.i_rst_n(rst_n),
		.i_d({I_SCK, I_SO, I_SI}),
		.o_q(pins_s)
	);

	assign sck_s = pins_s[2];
	assign so_s = pins_s[1];
	assign si_s = pins_s[0];

	// ----------------------------------------------------------------
	// Internal clock divider
	// ----------------------------------------------------------------
	tsp1_pkg::tsp1_core_t s_q;
	tsp1_pkg::tsp1_core_t s_d;
	tsp1_tick_if tk ();

	tsp1_clkdiv u_div (
		.i_clk(I_CLK),
		.i_rst_n(rst_n),
		.tk(tk.gen)
	);

	logic master;
	logic drive_clk;
	logic eff_sck;
	logic rise;
	logic fall;
	logic in_bit;
	logic clear_evt;
	logic running;

	assign master = (s_q.cksel != 2'h0);
	assign drive_clk = master && I_CLK_DIR;
	assign running = (s_q.state == tsp1_pkg::TSP1_ST_RUN);
	assign tk.sel = s_q.cksel;
	assign tk.run = running && master;
	// Counter watches the internal clock when a master drives the clock pin, else the synchronised pin level
	assign eff_sck = drive_clk ? s_q.sck_int : sck_s;
	assign rise = eff_sck && !s_q.sck_prev;
	assign fall = !eff_sck && s_q.sck_prev;
	assign in_bit = I_DI_DIR ? I_PORT_LATCH[0] : si_s;
	assign clear_evt = I_WDT_RST || I_CE_RST || I_CLK_STOP;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.irq = 1'b0;
		s_d.sck_prev = eff_sck;
		if (running) begin
			if (tk.tick && master) begin
				s_d.sck_int = !s_q.sck_int;
			end
			if (fall) begin
				s_d.so_bit = s_q.sr[7];
			end
			if (rise) begin
				s_d.sr = {s_q.sr[6:0], in_bit};
				if (s_q.cnt == 4'(`TSP1_BITS - 1)) begin
					s_d.cnt = 4'h0;
					s_d.irq = 1'b1;
					s_d.state = tsp1_pkg::TSP1_ST_WAIT;
					s_d.ts = 1'b0;
					s_d.sck_int = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
			end
		end
		// Shift register is frozen in wait, so edges there change nothing
		if (I_SFR_WR) begin
			if (!running) begin
				s_d.sr = I_SFR_WDATA;
			end else if (eff_sck) begin
				s_d.sr = I_SFR_WDATA;
				s_d.so_bit = I_SFR_WDATA[7];
			end
		end
		if (I_MODE_WR) begin
			s_d.hiz = I_MODE_WDATA[`TSP1_HIZ_BIT];
			s_d.cksel = {I_MODE_WDATA[`TSP1_CKH_BIT], I_MODE_WDATA[`TSP1_CKL_BIT]};
			if (I_MODE_WDATA[`TSP1_TS_BIT]) begin
				// A set in the completion cycle wins and releases again
				s_d.state = tsp1_pkg::TSP1_ST_RUN;
				s_d.ts = 1'b1;
			end else begin
				s_d.state = tsp1_pkg::TSP1_ST_WAIT;
				s_d.ts = 1'b0;
				s_d.cnt = 4'h0;
				s_d.sck_int = 1'b1;
			end
		end
		if (clear_evt) begin
			s_d.state = tsp1_pkg::TSP1_ST_WAIT;
			s_d.ts = 1'b0;
			s_d.hiz = 1'b0;
			s_d.cksel = 2'h0;
			s_d.cnt = 4'h0;
			s_d.sck_int = 1'b1;
		end
		// Pin drivers and read-back, registered so outputs come from flops
		s_d.sck_oe = I_CLK_DIR;
		s_d.sck_o = (s_d.cksel != 2'h0) ? s_d.sck_int : I_PORT_LATCH[2];
		s_d.so_oe = I_DO_DIR;
		s_d.so_o = s_d.hiz ? s_d.so_bit : I_PORT_LATCH[1];
		s_d.si_oe = I_DI_DIR;
		s_d.si_o = I_PORT_LATCH[0];
		s_d.sfr_rd = s_d.sr;
		s_d.mode_rd = {s_d.ts, s_d.hiz, s_d.cksel};
		s_d.pin_rd = {sck_s, so_s, si_s};
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.sck_int <= 1'b1;
			s_q.sck_prev <= 1'b1;
			s_q.sck_o <= 1'b1;
			s_q.sr <= `TSP1_SFR_RST;
			s_q.mode_rd <= `TSP1_MODE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign O_MODE_RDATA = s_q.mode_rd;
	assign O_SFR_RDATA = s_q.sfr_rd;
	assign O_PIN_RDATA = s_q.pin_rd;
	assign O_SCK = s_q.sck_o;
	assign O_SCK_OE = s_q.sck_oe;
	assign O_SO = s_q.so_o;
	assign O_SO_OE = s_q.so_oe;
	assign O_SI = s_q.si_o;
	assign O_SI_OE = s_q.si_oe;
	assign O_IRQ = s_q.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!rst_n);

	logic quiet;
	assign quiet = !I_MODE_WR && !clear_evt && !I_SFR_WR;

	sequence s_eighth_rise;
		running && rise && (s_q.cnt == 4'h7) && quiet;
	endsequence

	sequence s_wait_entered;
		(s_q.state == tsp1_pkg::TSP1_ST_WAIT) && !s_q.ts && (s_q.cnt == 4'h0) && O_IRQ;
	endsequence

	a_irq_at_eight: assert property (s_eighth_rise |=> s_wait_entered)
		else $error("eighth rise did not raise irq and enter wait");
	a_irq_cause: assert property (O_IRQ |-> $past(running) && $past(rise) && ($past(s_q.cnt) == 4'h7))
		else $error("irq without eighth rise");
	a_done_clears_ts: assert property (s_eighth_rise |=> !O_MODE_RDATA[3] ##1 !O_MODE_RDATA[3])
		else $error("start flag still set after completion");
	a_forced_wait: assert property ((running && I_MODE_WR && !I_MODE_WDATA[3] && !clear_evt)
		|=> (s_q.state == tsp1_pkg::TSP1_ST_WAIT) && (s_q.cnt == 4'h0) && !O_IRQ)
		else $error("forced wait not taken");
	a_restart_keeps: assert property ((running && I_MODE_WR && I_MODE_WDATA[3] && !rise && !clear_evt)
		|=> running && (s_q.cnt == $past(s_q.cnt)) && (s_q.sck_int == ($past(s_q.sck_int) ^ $past(tk.tick))))
		else $error("repeated start disturbed clock or counter");
	a_release_start: assert property ((!running && I_MODE_WR && I_MODE_WDATA[3] && !clear_evt)
		|=> running ##1 O_MODE_RDATA[3])
		else $error("start did not release wait");
	a_count_step: assert property ((running && rise && (s_q.cnt != 4'h7) && quiet)
		|=> s_q.cnt == $past(s_q.cnt) + 4'h1)
		else $error("clock counter did not step");
	a_shift_in: assert property ((running && rise && quiet)
		|=> s_q.sr == {$past(s_q.sr[6:0]), $past(in_bit)})
		else $error("serial input not shifted into lsb");
	a_msb_out: assert property ((running && fall && !I_SFR_WR && !I_MODE_WR && !clear_evt && s_q.hiz && I_DO_DIR)
		|=> ##1 O_SO == $past(s_q.sr[7], 2))
		else $error("msb not presented at falling edge");
	a_wait_hold: assert property ((!running && quiet) |=> $stable(s_q.sr) && $stable(s_q.cnt))
		else $error("shift register or counter moved in wait");
	a_master_high: assert property (((s_q.state == tsp1_pkg::TSP1_ST_WAIT) && master && !I_MODE_WR && !clear_evt)
		|=> O_SCK)
		else $error("master clock pin not high in wait");
	a_clear_evt: assert property (clear_evt |=> (s_q.cnt == 4'h0) && (s_q.cksel == 2'h0) ##1 (O_MODE_RDATA == 4'h0))
		else $error("reset event did not clear counter and mode");
	a_write_high: assert property ((running && I_SFR_WR && eff_sck && !clear_evt)
		|=> (s_q.so_bit == $past(I_SFR_WDATA[7])) && (s_q.sr == $past(I_SFR_WDATA)))
		else $error("write with clock high not taken");
	a_low_write: assert property ((running && I_SFR_WR && !eff_sck && !I_MODE_WR && !clear_evt)
		|=> s_q.sr == $past(s_q.sr))
		else $error("write with clock low was stored");
	a_wait_write: assert property ((!running && I_SFR_WR && !clear_evt)
		|=> O_SFR_RDATA == $past(I_SFR_WDATA))
		else $error("write in wait not read back");
	a_mode_back: assert property ((I_MODE_WR && !clear_evt)
		|=> O_MODE_RDATA[2:0] == $past(I_MODE_WDATA[2:0]))
		else $error("mode fields not read back");
	a_flag_shows_run: assert property (O_MODE_RDATA[3] == running)
		else $error("start flag does not show transfer state");
	a_irq_pulse: assert property (O_IRQ |=> !O_IRQ)
		else $error("interrupt request longer than one cycle");

	// ----------------------------------------------------------------
	// Checks: pin steering
	// ----------------------------------------------------------------
	// Attempts start one edge after release, so reset values never meet a live past value
	a_sck_dir: assert property (1'b1 |=> O_SCK_OE == $past(I_CLK_DIR))
		else $error("clock pin enable does not follow direction");
	a_so_dir: assert property (1'b1 |=> O_SO_OE == $past(I_DO_DIR))
		else $error("data out enable does not follow direction");
	a_si_port: assert property (1'b1 |=> (O_SI == $past(I_PORT_LATCH[0])) && (O_SI_OE == $past(I_DI_DIR)))
		else $error("data in pin does not drive port latch");
	a_so_port: assert property ((!s_q.hiz && !I_MODE_WR && !clear_evt)
		|=> O_SO == $past(I_PORT_LATCH[1]))
		else $error("data out pin not general purpose");
	a_slave_pin: assert property ((!master && !I_MODE_WR && !clear_evt)
		|=> O_SCK == $past(I_PORT_LATCH[2]))
		else $error("slave clock pin not general purpose");
	a_latch_in: assert property ((running && rise && quiet && I_DI_DIR)
		|=> s_q.sr[0] == $past(I_PORT_LATCH[0]))
		else $error("port latch not shifted in with data pin as output");
	a_clear_port: assert property (clear_evt |=> (O_SO == $past(I_PORT_LATCH[1])) && s_q.sck_int)
		else $error("reset event left serial function on");

	// ----------------------------------------------------------------
	// Checks: internal clock
	// ----------------------------------------------------------------
	sequence s_plain_tick;
		running && master && tk.tick && quiet && !(rise && (s_q.cnt == 4'h7));
	endsequence

	a_tick_toggle: assert property (s_plain_tick |=> s_q.sck_int != $past(s_q.sck_int))
		else $error("divider tick did not toggle internal clock");
	a_wait_clock_high: assert property (!running |=> s_q.sck_int)
		else $error("internal clock low in wait");
	a_div_quiet: assert property (!tk.run |=> !tk.tick)
		else $error("divider ticked while stopped");
endmodule : tsp1_top
`default_nettype wire

// *** tb/tsp1_bench.sv ***
// Self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module tsp1_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wdt = 1'b0;
	logic ce = 1'b0;
	logic cstop = 1'b0;
	logic mwr = 1'b0;
	logic [3:0] mwd = 4'h0;
	logic swr = 1'b0;
	logic [7:0] swd = 8'h00;
	logic cdir = 1'b1;
	logic ddir = 1'b1;
	logic idir = 1'b0;
	logic [2:0] latch = 3'h0;
	logic go = 1'b0;
	logic slave = 1'b0;
	logic [7:0] ptx = 8'h00;
	logic [3:0] mrd;
	logic [7:0] srd;
	logic [7:0] prx;
	logic [2:0] prd;
	logic sck_o, sck_oe, so_o, so_oe, si_o, si_oe, irq, p_sck, p_si, sck_d;
	logic sck_w, so_w, si_w;
	int fails = 0;
	int total_checks = 0;
	int rises = 0;
	int irqs = 0;
	int lcnt = 0;
	int low_w = 0;
	// Wire levels from the port's enables; an undriven data out wire shows the inverse level
	assign sck_w = sck_oe ? sck_o : p_sck;
	assign so_w = so_oe ? so_o : ~so_o;
	assign si_w = si_oe ? si_o : p_si;
	tsp1_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_WDT_RST(wdt), .I_CE_RST(ce), .I_CLK_STOP(cstop),
		.I_MODE_WR(mwr), .I_MODE_WDATA(mwd), .O_MODE_RDATA(mrd), .I_SFR_WR(swr), .I_SFR_WDATA(swd),
		.O_SFR_RDATA(srd), .I_CLK_DIR(cdir), .I_DO_DIR(ddir), .I_DI_DIR(idir), .I_PORT_LATCH(latch),
		.O_PIN_RDATA(prd), .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE(sck_oe), .I_SO(so_w), .O_SO(so_o),
		.O_SO_OE(so_oe), .I_SI(si_w), .O_SI(si_o), .O_SI_OE(si_oe), .O_IRQ(irq));
	tsp1_peer peer (.i_clk(clk), .i_go(go), .i_slave(slave), .i_tx(ptx), .i_sck(sck_w), .i_so(so_w),
		.o_sck(p_sck), .o_si(p_si), .o_rx(prx));
	initial begin
		forever #20 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Clock pin edges, low width and interrupt pulses
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		sck_d <= sck_w;
		if (sck_w && !sck_d) rises <= rises + 1;
		if (!sck_w) lcnt <= lcnt + 1;
		else if (!sck_d) low_w <= lcnt;
		if (sck_w) lcnt <= 0;
		if (irq === 1'b1) irqs <= irqs + 1;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic test_done;
		if (fails == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	// One write strobe: mode register when m is set, shift register otherwise
	task automatic wr(input bit m, input logic [7:0] d);
		mwr <= m;
		swr <= !m;
		mwd <= d[3:0];
		swd <= d;
		@(posedge clk);
		mwr <= 1'b0;
		swr <= 1'b0;
		@(posedge clk);
	endtask : wr
	// Bounded wait for end of transfer, or until the clock pin rise count reaches k
	task automatic wait_on(input bit idle, input int k);
		int n;
		n = 0;
		while ((idle ? mrd[3] !== 1'b0 : rises < k) && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) fails++;
		tick(4);
	endtask : wait_on
	task automatic xfer(input logic [1:0] cs, input logic [7:0] d, input logic [7:0] pd, input bit again,
		input int hp);
		int r0;
		int i0;
		r0 = rises;
		i0 = irqs;
		wr(1'b0, d);
		ptx <= pd;
		slave <= (cs == 2'b00);
		cdir <= (cs != 2'b00);
		go <= 1'b1;
		wr(1'b1, {6'h03, cs});
		go <= 1'b0;
		chk(16'(mrd[3]), 16'h1);
		if (again) begin
			wait_on(1'b0, r0 + 3);
			wr(1'b1, {6'h03, cs});
		end
		wait_on(1'b1, 0);
		chk(16'(rises - r0), 16'h8);
		chk(16'(irqs - i0), 16'h1);
		chk(16'(srd), 16'(pd));
		chk(16'(prx), 16'(d));
		chk(16'(mrd), 16'({2'b01, cs}));
		chk(16'(sck_w), 16'h1);
		if (hp > 0) chk(16'(low_w), 16'(hp));
	endtask : xfer
	initial begin
		int r0;
		int i0;
		repeat (16) @(posedge clk);
		chk(16'({sck_o, sck_oe, so_oe, si_oe}), 16'h8);
		rst_b <= 1'b1;
		tick(3);
		chk(16'(mrd), 16'h0);
		// ----------------------------------------------------------------
		// Pin steering in wait, slave, data in pin as output
		// ----------------------------------------------------------------
		cdir <= 1'b0;
		idir <= 1'b1;
		// Ends with the clock latch high, so leaving slave mode shows no false rise on the pin
		for (int v = 2; v <= 5; v += 3) begin
			latch <= 3'(v);
			tick(3);
			chk(16'({sck_o, so_o, si_o}), 16'(v));
			chk(16'({sck_oe, si_oe}), 16'h1);
			tick(2);
			chk(16'(prd), 16'({1'b1, 2'(v)}));
		end
		idir <= 1'b0;
		xfer(2'b10, 8'hA5, 8'h3C, 1'b0, 33);
		xfer(2'b01, 8'h5A, 8'hC3, 1'b1, 66);
		xfer(2'b11, 8'h80, 8'h01, 1'b0, 266);
		xfer(2'b00, 8'h01, 8'hFE, 1'b1, 0);
		// Forced wait in mid-frame, then a full frame again
		cdir <= 1'b1;
		r0 = rises;
		i0 = irqs;
		wr(1'b1, 8'h0E);
		wait_on(1'b0, r0 + 3);
		wr(1'b0, 8'hC3);
		chk(16'(srd), 16'hC3);
		chk(16'(so_o), 16'h1);
		wr(1'b1, 8'h06);
		chk(16'(mrd), 16'h6);
		tick(80);
		chk(16'(irqs - i0), 16'h0);
		chk(16'(sck_w), 16'h1);
		xfer(2'b10, 8'h3C, 8'h96, 1'b0, 33);
		// Reset events in mid-frame
		for (int k = 0; k < 3; k++) begin
			wr(1'b1, 8'h0E);
			wait_on(1'b0, rises + 2);
			{cstop, ce, wdt} <= 3'(1 << k);
			tick(1);
			{cstop, ce, wdt} <= 3'h0;
			tick(2);
			chk(16'(mrd), 16'h0);
			xfer(2'b10, 8'(k), 8'(~k), 1'b0, 33);
		end
		test_done;
	end
	initial begin
		#1000000;
		fails++;
		test_done;
	end
endmodule : tsp1_bench
`default_nettype wire

// *** tb/tsp1_peer.sv ***
// Serial peer model on the far side of the three-wire link
`timescale 1ns/1ps
`default_nettype none
module tsp1_peer (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_slave,
	input wire logic [7:0] i_tx,
	input wire logic i_sck,
	input wire logic i_so,
	output logic o_sck,
	output logic o_si,
	output logic [7:0] o_rx
);
	logic [7:0] tx_q;
	int n;
	initial begin
		o_sck = 1'b1;
		o_si = 1'b0;
		o_rx = 8'h00;
		tx_q = 8'h00;
		n = 8;
	end
	// ----------------------------------------------------------------
	// Frame start: own clock only when the port is slave
	// ----------------------------------------------------------------
	always @(posedge i_go) begin
		tx_q = i_tx;
		n = 0;
		#7;
		repeat (i_slave ? 8 : 0) begin
			#160 o_sck = 1'b0;
			#160 o_sck = 1'b1;
		end
	end
	always @(negedge i_sck) begin
		o_si = tx_q[7];
		tx_q = {tx_q[6:0], 1'b0};
	end
	// Sample late: the port output lags a slave clock edge by a few cycles
	always @(posedge i_sck) begin
		repeat (3) @(posedge i_clk);
		o_rx = {o_rx[6:0], i_so};
		n = n + 1;
	end
	// Released line shows no stale level
	always @(posedge i_clk) begin
		if (n >= 8) o_si = ~o_si;
	end
endmodule : tsp1_peer
`default_nettype wire
